// ===== src/oag_consts.svh
`ifndef OAG_CONSTS_SVH
`define OAG_CONSTS_SVH
`define OAG_PC_STEP 16'h0002
`define OAG_ZERO16 16'h0000
`define OAG_ZERO8 8'h00
`define OAG_LONG_BIT 7
`define OAG_SEG_HI 14
`define OAG_SEG_LO 8
`define OAG_SHORT_HI 7
`define OAG_SHORT_LO 0
`define OAG_REG_ZERO 4'h0
`define OAG_REG_ONE 4'h1
`define OAG_REG_SP_HI 4'he
`define OAG_REG_SP 4'hf
`endif

// ===== src/oag_pkg.sv
package oag_pkg;
  typedef enum logic [2:0] {
    OAG_MODE_REG, OAG_MODE_IMM, OAG_MODE_IND, OAG_MODE_DIR,
    OAG_MODE_IDX, OAG_MODE_BASE, OAG_MODE_REL
  } oag_mode_type;
  typedef enum logic [2:0] {
    OAG_SPACE_REG, OAG_SPACE_PROG, OAG_SPACE_DATA, OAG_SPACE_STACK,
    OAG_SPACE_IO, OAG_SPACE_SIO
  } oag_space_type;
  typedef enum logic [1:0] {
    OAG_KIND_MEM, OAG_KIND_IO, OAG_KIND_SIO, OAG_KIND_JUMP
  } oag_kind_type;
  typedef enum logic [1:0] {
    OAG_IMPL_NONE, OAG_IMPL_XLATE, OAG_IMPL_EXT, OAG_IMPL_INTACK
  } oag_impl_type;
endpackage

// ===== src/oag_addr_word.sv
`timescale 1ns/100ps
`default_nettype none
`include "oag_consts.svh"
// Splits an embedded address word into long flag, segment and short offset.
module oag_addr_word
  import oag_pkg::*;
(
  input wire logic [15:0] word_in,
  output logic long_out,
  output logic [6:0] seg_out,
  output logic [15:0] short_off_out
);
  assign long_out = word_in[`OAG_LONG_BIT + `OAG_SEG_LO];
  assign seg_out = word_in[`OAG_SEG_HI:`OAG_SEG_LO];
  // Upper offset byte assumed zero
  assign short_off_out = {`OAG_ZERO8, word_in[`OAG_SHORT_HI:`OAG_SHORT_LO]};
endmodule
`default_nettype wire

// ===== src/oag_core.sv
`timescale 1ns/100ps
`default_nettype none
`include "oag_consts.svh"
module oag_core
  import oag_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [15:0] pc_reset_in,
  input wire logic start_in,
  input wire logic [2:0] mode_in,
  input wire logic [1:0] kind_in,
  input wire logic [1:0] impl_in,
  input wire logic seg_mode_in,
  input wire logic sys_mode_in,
  input wire logic [3:0] reg_sel_in,
  input wire logic [15:0] reg_val_in,
  input wire logic [15:0] reg_hi_val_in,
  input wire logic [15:0] disp_in,
  input wire logic fetch_in,
  input wire logic [15:0] word_in,
  input wire logic step_in,
  input wire logic step_down_in,
  input wire logic [15:0] step_size_in,
  output logic want_word_out,
  output logic [15:0] fetch_addr_out,
  output logic done_out,
  output logic [15:0] ea_out,
  output logic [6:0] ea_seg_out,
  output logic [2:0] space_out,
  output logic [15:0] imm_out,
  output logic pc_load_out,
  output logic [15:0] pc_out,
  output logic [3:0] phys_reg_out,
  output logic phys_sys_bank_out,
  output logic [3:0] impl_reg_out,
  output logic impl_byte_out,
  output logic [15:0] ptr_step_out
);
  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic is_stack_ptr(input logic [3:0] r, input logic seg);
    is_stack_ptr = seg ? (r == `OAG_REG_SP_HI) : (r == `OAG_REG_SP);
  endfunction

  typedef enum {ST_IDLE, ST_ADDR, ST_LONG, ST_DONE} oag_state_type;
  oag_state_type state_r, state_nxt;
  logic [15:0] pc_r, pc_nxt;
  logic pc_seeded_r;
  logic [2:0] mode_r;
  logic [1:0] kind_r;
  logic [3:0] reg_r;
  logic seg_r;
  logic [15:0] regv_r, disp_r, ea_r, imm_r;
  logic [6:0] seg_num_r;
  logic [2:0] space_r;
  logic pc_load_r, done_r;
  logic [15:0] step_r;

  wire aw_long;
  wire [6:0] aw_seg;
  wire [15:0] aw_short;
  oag_addr_word u_aw (
    .word_in(word_in),
    .long_out(aw_long),
    .seg_out(aw_seg),
    .short_off_out(aw_short)
  );

  // ----------------------------------------
  // Address arithmetic and space select
  // ----------------------------------------
  wire needs_addr = (mode_r == OAG_MODE_DIR) || (mode_r == OAG_MODE_IDX)
                    || (mode_r == OAG_MODE_BASE) || (mode_r == OAG_MODE_IMM);
  wire [15:0] pc_inc = pc_r + `OAG_PC_STEP;
  wire [15:0] rel_ea = pc_r + disp_r;
  wire [15:0] idx_ea_short = aw_short + regv_r;
  wire [15:0] idx_ea_long = word_in + regv_r;
  wire is_io = (kind_r == OAG_KIND_IO);
  wire is_sio = (kind_r == OAG_KIND_SIO);
  wire sp_used = is_stack_ptr(reg_r, seg_r);
  wire [2:0] io_or = is_io ? 3'(OAG_SPACE_IO) : 3'(OAG_SPACE_SIO);
  wire [2:0] ind_space = (is_io || is_sio) ? io_or
                         : (sp_used ? 3'(OAG_SPACE_STACK) : 3'(OAG_SPACE_DATA));
  wire [2:0] dir_space = (is_io || is_sio) ? io_or
                         : (kind_r == OAG_KIND_JUMP ? 3'(OAG_SPACE_PROG)
                            : 3'(OAG_SPACE_DATA));
  wire [2:0] base_space = sp_used ? 3'(OAG_SPACE_STACK) : 3'(OAG_SPACE_DATA);
  // I/O addresses and nonsegmented addresses never take the long form
  wire seg_addr = seg_r && !is_io && !is_sio;
  wire take_long = seg_addr && aw_long;
  wire [15:0] one_word_ea = seg_addr ? aw_short : word_in;
  wire [15:0] ptr_adj = step_down_in ? (regv_r - step_size_in) : (regv_r + step_size_in);

  // Upper stack registers remapped in system mode
  wire upper_sp = (reg_sel_in == `OAG_REG_SP)
                  || (seg_mode_in && reg_sel_in == `OAG_REG_SP_HI);
  wire [3:0] impl_reg = (impl_in == OAG_IMPL_XLATE) ? `OAG_REG_ONE
                        : (impl_in == OAG_IMPL_EXT) ? `OAG_REG_ZERO
                        : `OAG_REG_SP;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start_in) begin
          state_nxt = ST_ADDR;
        end
      end
      ST_ADDR: begin
        if (!needs_addr) begin
          state_nxt = ST_DONE;
        end else if (fetch_in) begin
          state_nxt = (take_long && mode_r != OAG_MODE_IMM) ? ST_LONG : ST_DONE;
        end
      end
      ST_LONG: begin
        if (fetch_in) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_comb begin
    pc_nxt = pc_r;
    if (!pc_seeded_r) begin
      pc_nxt = pc_reset_in;
    end else if (want_word_out && fetch_in) begin
      pc_nxt = pc_inc;
    end else if (state_r == ST_DONE && pc_load_r) begin
      pc_nxt = ea_r;
    end
  end

  assign want_word_out = (state_r == ST_LONG) || (state_r == ST_ADDR && needs_addr);
  assign fetch_addr_out = {pc_r[15:1], 1'b0};

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r <= ST_IDLE;
      pc_r <= `OAG_ZERO16;
      pc_seeded_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pc_r <= pc_nxt;
      pc_seeded_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mode_r <= 3'(OAG_MODE_REG);
      kind_r <= 2'(OAG_KIND_MEM);
      reg_r <= `OAG_REG_ZERO;
      seg_r <= 1'b0;
      regv_r <= `OAG_ZERO16;
      disp_r <= `OAG_ZERO16;
    end else if (state_r == ST_IDLE && start_in) begin
      mode_r <= mode_in;
      kind_r <= kind_in;
      reg_r <= reg_sel_in;
      seg_r <= seg_mode_in;
      regv_r <= reg_val_in;
      disp_r <= disp_in;
    end
  end

  // ----------------------------------------
  // Result registers
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ea_r <= `OAG_ZERO16;
      seg_num_r <= 7'h00;
      space_r <= 3'(OAG_SPACE_REG);
      imm_r <= `OAG_ZERO16;
      pc_load_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= (state_r == ST_DONE);
      if (state_r == ST_ADDR) begin
        pc_load_r <= (mode_r == OAG_MODE_DIR) && (kind_r == OAG_KIND_JUMP);
        case (mode_r)
          OAG_MODE_REG: space_r <= 3'(OAG_SPACE_REG);
          OAG_MODE_IND: begin
            space_r <= ind_space;
            ea_r <= regv_r;
          end
          OAG_MODE_REL: begin
            space_r <= 3'(OAG_SPACE_PROG);
            ea_r <= rel_ea;
          end
          OAG_MODE_IMM: begin
            if (fetch_in) begin
              imm_r <= word_in;
              space_r <= 3'(OAG_SPACE_PROG);
            end
          end
          OAG_MODE_DIR: begin
            space_r <= dir_space;
            if (fetch_in) begin
              seg_num_r <= seg_addr ? aw_seg : 7'h00;
              ea_r <= one_word_ea;
            end
          end
          default: begin
            space_r <= (mode_r == OAG_MODE_IDX) ? 3'(OAG_SPACE_DATA) : base_space;
            if (fetch_in) begin
              seg_num_r <= seg_addr ? aw_seg : 7'h00;
              ea_r <= (mode_r == OAG_MODE_IDX && seg_addr) ? idx_ea_short
                      : word_in + regv_r;
            end
          end
        endcase
      end else if (state_r == ST_LONG && fetch_in) begin
        ea_r <= (mode_r == OAG_MODE_DIR) ? word_in : idx_ea_long;
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      step_r <= `OAG_ZERO16;
    end else if (step_in) begin
      step_r <= ptr_adj;
    end
  end

  assign done_out = done_r;
  assign ea_out = ea_r;
  assign ea_seg_out = seg_num_r;
  assign space_out = space_r;
  assign imm_out = imm_r;
  assign pc_load_out = pc_load_r;
  assign pc_out = pc_r;
  assign phys_reg_out = reg_sel_in;
  assign phys_sys_bank_out = sys_mode_in && upper_sp;
  assign impl_reg_out = impl_reg;
  assign impl_byte_out = (impl_in == OAG_IMPL_XLATE);
  assign ptr_step_out = step_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  pc_step_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (pc_seeded_r && want_word_out && fetch_in) |=> pc_r == $past(pc_r) + `OAG_PC_STEP)
    else $error("pc not stepped by one word");
  // Fetch address is forced even, so watch the pc itself for a stray odd value
  fetch_even_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    pc_seeded_r |-> pc_r[0] == 1'b0) else $error("odd program counter");
  sys_bank_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (sys_mode_in && reg_sel_in == `OAG_REG_SP) |-> phys_sys_bank_out)
    else $error("system copy not selected");
  rel_space_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (state_r == ST_ADDR && mode_r == OAG_MODE_REL) |=> space_r == 3'(OAG_SPACE_PROG))
    else $error("relative not program space");
  rel_target_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (state_r == ST_ADDR && mode_r == OAG_MODE_REL) |=> ea_r == $past(pc_r) + $past(disp_r))
    else $error("relative target wrong");
  short_fmt_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (state_r == ST_ADDR && mode_r == OAG_MODE_DIR && fetch_in && seg_addr && !aw_long)
    |=> (ea_r[15:8] == `OAG_ZERO8) ##1 done_r)
    else $error("short format wrong");
  long_fmt_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (state_r == ST_ADDR && mode_r == OAG_MODE_DIR && fetch_in && take_long)
    |=> state_r == ST_LONG) else $error("long format not taken");
  xlate_reg_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (impl_in == OAG_IMPL_XLATE) |-> (impl_reg_out == `OAG_REG_ONE && impl_byte_out))
    else $error("translate register wrong");
  ext_reg_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (impl_in == OAG_IMPL_EXT) |-> impl_reg_out == `OAG_REG_ZERO)
    else $error("extended register wrong");
  jump_load_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (state_r == ST_DONE && pc_load_r) |=> pc_r == $past(ea_r))
    else $error("jump not loaded");
endmodule
`default_nettype wire

// ===== verif/oag_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module oag_mem_model (
  input wire logic clk_in,
  input wire logic want_word_in,
  input wire logic [15:0] fetch_addr_in,
  input wire logic [3:0] delay_in,
  output logic fetch_out,
  output logic [15:0] word_out,
  output logic odd_seen_out
);
  logic [15:0] mem [0:63];
  logic [3:0] wait_r;
  initial begin
    fetch_out = 1'b0;
    word_out = 16'h0000;
    odd_seen_out = 1'b0;
    wait_r = 4'h0;
  end
  // Stale word is inverted each cycle so nothing leans on old data
  always @(negedge clk_in) begin
    if (want_word_in && wait_r >= delay_in) begin
      fetch_out <= 1'b1;
      word_out <= mem[fetch_addr_in[6:1]];
      wait_r <= 4'h0;
      odd_seen_out <= odd_seen_out | fetch_addr_in[0];
    end else begin
      fetch_out <= 1'b0;
      word_out <= ~word_out;
      wait_r <= want_word_in ? wait_r + 4'h1 : 4'h0;
    end
  end
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import oag_pkg::*;
;
  typedef struct {
    oag_mode_type mode;
    oag_kind_type kind;
    logic seg;
    logic [3:0] sel;
    logic [15:0] val, w0, w1, ea;
    oag_space_type sp;
  } oag_row_type;
  logic clk, reset_n, start, seg, sys, fetch, step, step_down, want_word, done, pc_load;
  logic bank, impl_byte, odd_seen;
  logic [1:0] kind, impl;
  logic [2:0] mode, space;
  logic [3:0] sel, delay, phys_reg, impl_reg;
  logic [6:0] ea_seg;
  logic [15:0] pc_reset, rval, disp, word, step_size, fetch_addr, ea, imm, pc, ptr_step, pc_m;
  int miscompares = 0;
  int compares = 0;
  oag_row_type rows[$];
  oag_row_type r;
  oag_core oag_core_i (.clk_in(clk), .reset_n_in(reset_n), .pc_reset_in(pc_reset),
    .start_in(start), .mode_in(mode), .kind_in(kind), .impl_in(impl), .seg_mode_in(seg),
    .sys_mode_in(sys), .reg_sel_in(sel), .reg_val_in(rval), .reg_hi_val_in(16'h0000),
    .disp_in(disp), .fetch_in(fetch), .word_in(word), .step_in(step),
    .step_down_in(step_down), .step_size_in(step_size), .want_word_out(want_word),
    .fetch_addr_out(fetch_addr), .done_out(done), .ea_out(ea), .ea_seg_out(ea_seg),
    .space_out(space), .imm_out(imm), .pc_load_out(pc_load), .pc_out(pc),
    .phys_reg_out(phys_reg), .phys_sys_bank_out(bank), .impl_reg_out(impl_reg),
    .impl_byte_out(impl_byte), .ptr_step_out(ptr_step));
  oag_mem_model mem_i (.clk_in(clk), .want_word_in(want_word), .fetch_addr_in(fetch_addr),
    .delay_in(delay), .fetch_out(fetch), .word_out(word), .odd_seen_out(odd_seen));
  // ----------------------------------------
  // Compare and bus helpers
  // ----------------------------------------
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  function automatic oag_row_type mk(oag_mode_type m, oag_kind_type k, logic s,
    logic [3:0] rs, logic [15:0] v, logic [15:0] w0, logic [15:0] e, oag_space_type sp,
    logic [15:0] w1 = 16'h0000);
    return '{m, k, s, rs, v, w0, w1, e, sp};
  endfunction
  // Long form only for segmented memory addresses with the top bit set
  function automatic int words(input oag_row_type x);
    if (x.mode inside {OAG_MODE_REG, OAG_MODE_IND, OAG_MODE_REL}) return 0;
    if (x.mode inside {OAG_MODE_DIR, OAG_MODE_IDX} && x.seg && x.w0[15]
        && !(x.kind inside {OAG_KIND_IO, OAG_KIND_SIO})) return 2;
    return 1;
  endfunction
  task automatic issue(input oag_row_type x);
    mem_i.mem[pc_m[6:1]] = x.w0;
    mem_i.mem[pc_m[6:1] + 6'h01] = x.w1;
    @(negedge clk);
    mode = x.mode;
    kind = x.kind;
    seg = x.seg;
    sel = x.sel;
    rval = x.val;
    disp = x.val;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
  endtask
  task automatic finish_row(input oag_row_type x);
    int n;
    int k;
    logic [15:0] exp;
    n = words(x);
    exp = (x.mode == OAG_MODE_REL) ? pc_m + x.ea : x.ea;
    k = 0;
    while (done !== 1'b1 && k < 50) begin
      @(negedge clk);
      k++;
    end
    chk_bit(done, 1'b1);
    pc_m = pc_m + 16'(2 * n);
    if (x.mode == OAG_MODE_DIR && x.kind == OAG_KIND_JUMP) pc_m = x.ea;
    if (!(x.mode inside {OAG_MODE_REG, OAG_MODE_IMM}))
      chk_val(ea, exp);
    if (x.mode == OAG_MODE_IMM) chk_val(imm, x.w0);
    if (n > 0 && x.seg && !(x.kind inside {OAG_KIND_IO, OAG_KIND_SIO})
        && x.mode inside {OAG_MODE_DIR, OAG_MODE_IDX})
      chk_val({9'h000, ea_seg}, {9'h000, x.w0[14:8]});
    chk_val({13'h0000, space}, {13'h0000, x.sp});
    chk_val(pc, pc_m);
    chk_bit(pc_load, x.mode == OAG_MODE_DIR && x.kind == OAG_KIND_JUMP);
  endtask
  task automatic do_reset(input logic [15:0] start_pc);
    @(negedge clk);
    reset_n = 1'b0;
    pc_reset = start_pc;
    #1;
    chk_val(ea, 16'h0000);
    chk_bit(done, 1'b0);
    chk_val({13'h0000, space}, {13'h0000, OAG_SPACE_REG});
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    pc_m = start_pc;
    chk_val(pc, start_pc);
    $display("test reset done");
  endtask
  // ----------------------------------------
  // Clock, watchdog and test sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #80000;
    miscompares++;
    $display("test watchdog expired");
    results();
  end
  initial begin
    {reset_n, start, seg, sys, step, step_down, kind, impl, mode, sel} = '0;
    {rval, disp, step_size, pc_reset, pc_m, delay} = '0;
    do_reset(16'h0100);
    // No row uses register zero as a pointer
    add_rows();
    foreach (rows[i]) begin
      delay = 4'(i % 3);
      issue(rows[i]);
      finish_row(rows[i]);
    end
    $display("test rows done");
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      impl = i[1:0];
      #1;
      chk_val({12'h000, impl_reg}, impl == OAG_IMPL_XLATE ? 16'h0001 :
        impl == OAG_IMPL_EXT ? 16'h0000 : 16'h000f);
      chk_bit(impl_byte, impl == OAG_IMPL_XLATE);
    end
    for (int i = 0; i < 12; i++) begin
      @(negedge clk);
      sel = 4'(13 + i % 3);
      sys = 1'((i / 3) % 2);
      seg = 1'(i / 6);
      #1;
      chk_bit(bank, sys && (sel == 4'hf || (sel == 4'he && seg)));
      chk_val({12'h000, phys_reg}, {12'h000, sel});
    end
    $display("test banks done");
    r = mk(OAG_MODE_IND, OAG_KIND_MEM, 1'b0, 4'h6, 16'h1000, 16'h0000, 16'h1000, OAG_SPACE_DATA);
    issue(r);
    finish_row(r);
    @(negedge clk);
    {step, step_down, step_size} = {1'b1, 1'b0, 16'h0002};
    @(negedge clk);
    step = 1'b0;
    @(negedge clk);
    chk_val(ptr_step, 16'h1002);
    r = mk(OAG_MODE_IND, OAG_KIND_MEM, 1'b0, 4'h7, 16'h2000, 16'h0000, 16'h2000, OAG_SPACE_DATA);
    issue(r);
    finish_row(r);
    @(negedge clk);
    {step, step_down, step_size} = {1'b1, 1'b1, 16'h0004};
    @(negedge clk);
    step = 1'b0;
    @(negedge clk);
    chk_val(ptr_step, 16'h1ffc);
    $display("test steps done");
    // A start while the partner stalls must be ignored
    delay = 4'h4;
    r = mk(OAG_MODE_DIR, OAG_KIND_MEM, 1'b0, 4'h1, 16'h0000, 16'h6a02, 16'h6a02, OAG_SPACE_DATA);
    issue(r);
    @(negedge clk);
    mode = OAG_MODE_REG;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    finish_row(r);
    repeat (6) begin
      @(negedge clk);
      chk_bit(done, 1'b0);
    end
    $display("test refused start done");
    r = mk(OAG_MODE_IDX, OAG_KIND_MEM, 1'b0, 4'h3, 16'h0001, 16'h0100, 16'h0101, OAG_SPACE_DATA);
    issue(r);
    do_reset(16'h0200);
    delay = 4'h0;
    r = mk(OAG_MODE_REL, OAG_KIND_MEM, 1'b0, 4'h1, 16'h0010, 16'h0000, 16'h0010, OAG_SPACE_PROG);
    issue(r);
    finish_row(r);
    chk_bit(odd_seen, 1'b0);
    $display("test midrun reset done");
    results();
  end
  // ----------------------------------------
  // Ordinary cases: mode, kind, seg, reg, value, word, ea, space, word two
  // ----------------------------------------
  function automatic void add(oag_mode_type m, oag_kind_type k, logic s, logic [3:0] rs,
    logic [15:0] v, logic [15:0] w0, logic [15:0] e, oag_space_type sp,
    logic [15:0] w1 = 16'h0000);
    rows.push_back(mk(m, k, s, rs, v, w0, e, sp, w1));
  endfunction
  task automatic add_rows();
    add(OAG_MODE_REG, OAG_KIND_MEM, 0, 4'h3, 16'h1234, 16'h0000, 16'h0000, OAG_SPACE_REG);
    add(OAG_MODE_IMM, OAG_KIND_MEM, 0, 4'h2, 16'h0000, 16'h5555, 16'h0000, OAG_SPACE_PROG);
    add(OAG_MODE_IND, OAG_KIND_MEM, 0, 4'h5, 16'h170c, 16'h0000, 16'h170c, OAG_SPACE_DATA);
    add(OAG_MODE_IND, OAG_KIND_MEM, 0, 4'hf, 16'h2000, 16'h0000, 16'h2000, OAG_SPACE_STACK);
    add(OAG_MODE_IND, OAG_KIND_IO, 0, 4'h4, 16'h0040, 16'h0000, 16'h0040, OAG_SPACE_IO);
    add(OAG_MODE_IND, OAG_KIND_SIO, 0, 4'h4, 16'h0042, 16'h0000, 16'h0042, OAG_SPACE_SIO);
    add(OAG_MODE_IND, OAG_KIND_MEM, 1, 4'he, 16'h3000, 16'h0000, 16'h3000, OAG_SPACE_STACK);
    add(OAG_MODE_DIR, OAG_KIND_MEM, 0, 4'h1, 16'h0000, 16'h5e23, 16'h5e23, OAG_SPACE_DATA);
    add(OAG_MODE_DIR, OAG_KIND_IO, 0, 4'h1, 16'h0000, 16'h00ff, 16'h00ff, OAG_SPACE_IO);
    add(OAG_MODE_DIR, OAG_KIND_SIO, 0, 4'h1, 16'h0000, 16'h0102, 16'h0102, OAG_SPACE_SIO);
    add(OAG_MODE_DIR, OAG_KIND_IO, 1, 4'h1, 16'h0000, 16'h8123, 16'h8123, OAG_SPACE_IO);
    add(OAG_MODE_DIR, OAG_KIND_MEM, 1, 4'h1, 16'h0000, 16'h0512, 16'h0012, OAG_SPACE_DATA);
    add(OAG_MODE_DIR, OAG_KIND_MEM, 1, 4'h1, 16'h0000, 16'h8700, 16'habcd, OAG_SPACE_DATA,
      16'habcd);
    add(OAG_MODE_IDX, OAG_KIND_MEM, 0, 4'h3, 16'h01fe, 16'h231a, 16'h2518, OAG_SPACE_DATA);
    add(OAG_MODE_IDX, OAG_KIND_MEM, 1, 4'h3, 16'h0010, 16'h0234, 16'h0044, OAG_SPACE_DATA);
    add(OAG_MODE_BASE, OAG_KIND_MEM, 0, 4'h5, 16'h20aa, 16'h0018, 16'h20c2, OAG_SPACE_DATA);
    add(OAG_MODE_REL, OAG_KIND_MEM, 0, 4'h1, 16'h0006, 16'h0000, 16'h0006, OAG_SPACE_PROG);
    add(OAG_MODE_DIR, OAG_KIND_JUMP, 0, 4'h1, 16'h0000, 16'h0400, 16'h0400, OAG_SPACE_PROG);
    add(OAG_MODE_REL, OAG_KIND_MEM, 0, 4'h1, 16'hfffe, 16'h0000, 16'hfffe, OAG_SPACE_PROG);
    add(OAG_MODE_IMM, OAG_KIND_MEM, 1, 4'h2, 16'h0000, 16'haaaa, 16'h0000, OAG_SPACE_PROG);
    // Long index form, stack based operand and a long segmented jump
    add(OAG_MODE_IDX, OAG_KIND_MEM, 1, 4'h3, 16'h0010, 16'h8300, 16'h1244, OAG_SPACE_DATA,
      16'h1234);
    add(OAG_MODE_BASE, OAG_KIND_MEM, 0, 4'hf, 16'h3000, 16'h0010, 16'h3010, OAG_SPACE_STACK);
    add(OAG_MODE_DIR, OAG_KIND_JUMP, 1, 4'h1, 16'h0000, 16'h8100, 16'h0480, OAG_SPACE_PROG,
      16'h0480);
  endtask
endmodule
`default_nettype wire
